// *** design/apsi_ctrl.sv ***
`timescale 1ns/1ps

module apsi_ctrl
	import apsi_pkg::*;
#(
	parameter int POWERUP_CYCLES = POWERUP_CYCLES_DEF
)
(
	input wire logic clk,
	input wire logic reset,
	// User requests and read answers
	input wire logic reqValid,
	input wire logic reqWrite,
	input wire logic [ADDR_W-1:0] reqAddr,
	input wire logic [DATA_W-1:0] reqData,
	input wire logic [LANES-1:0] reqLaneEn,
	output logic reqReady,
	output logic rspValid,
	output logic [DATA_W-1:0] rspData,
	// Deep sleep request and status
	input wire logic sleepReq,
	output logic sleeping,
	output logic linkReady,
	// Memory pins, controls active low
	output logic chipSelectBar,
	output logic deep_sleep_bar,
	output logic outputEnableBar,
	output logic writeStrobeBar,
	output logic low_lane_enable_bar,
	output logic high_lane_enable_bar,
	output logic [ADDR_W-1:0] word_address,
	output logic [DATA_W-1:0] dataOut,
	output logic [LANES-1:0] dataOutEnBar,
	input wire logic [DATA_W-1:0] dataIn
);

	// Registered state and its next value
	apsi_ctrl_s r;
	apsi_ctrl_s next_r;

	// Load strobe and count toward the interval timer
	logic timerLoad;
	logic [TIMER_W-1:0] timerValue;
	logic timerExpired;

	// Interval timer for every wait
	apsi_timer u_timer (
		.clk(clk),
		.reset(reset),
		.load(timerLoad),
		.loadValue(timerValue),
		.expired(timerExpired)
	);

	// Sequencer for power-up, accesses and deep sleep
	always_comb begin
		next_r = r;
		next_r.rspValid = 1'b0;
		timerLoad = 1'b0;
		timerValue = '0;
		unique case (r.state)
			// Pins high, start the power-up wait
			ST_START: begin
				next_r.pins.chipSelectBar = 1'b1;
				next_r.pins.deepSleepBar = 1'b1;
				// A count of n gives n+1 cycles of wait
				timerLoad = 1'b1;
				timerValue = TIMER_W'(POWERUP_CYCLES);
				next_r.state = ST_POWERUP;
			end

			// Select and sleep stay high for the whole wait
			ST_POWERUP: begin
				if (timerExpired) begin
					next_r.linkReady = 1'b1;
					next_r.reqReady = 1'b1;
					next_r.state = ST_IDLE;
				end
			end

			// Take one request, a sleep request only when none is taken
			ST_IDLE: begin
				if (reqValid && r.reqReady) begin
					next_r.reqReady = 1'b0;
					next_r.pins.wordAddress = reqAddr;
					next_r.pins.chipSelectBar = 1'b0;
					next_r.pins.lowLaneEnableBar = ~reqLaneEn[0];
					next_r.pins.highLaneEnableBar = ~reqLaneEn[1];
					if (reqWrite) begin
						// Write: strobe low, drive only the enabled lanes
						next_r.pins.writeStrobeBar = 1'b0;
						next_r.pins.outputEnableBar = 1'b1;
						next_r.pins.dataOut = reqData;
						next_r.pins.dataOutEnBar = ~reqLaneEn;
						timerLoad = 1'b1;
						timerValue = TIMER_W'(WRITE_PULSE_CYCLES);
						next_r.state = ST_WRITE;
					end else begin
						// Read: our lanes stay released so the memory can drive
						next_r.pins.outputEnableBar = 1'b0;
						timerLoad = 1'b1;
						timerValue = TIMER_W'(READ_CYCLES);
						next_r.state = ST_READ;
					end
				end else if (sleepReq) begin
					// Contents are lost from here on
					next_r.reqReady = 1'b0;
					next_r.linkReady = 1'b0;
					next_r.pins.deepSleepBar = 1'b0;
					timerLoad = 1'b1;
					timerValue = TIMER_W'(SUSPEND_CYCLES);
					next_r.state = ST_SUSPEND;
				end
			end

			// Hold the read five cycles, then sample the lanes
			ST_READ: begin
				if (timerExpired) begin
					next_r.rspData = dataIn;
					next_r.rspValid = 1'b1;
					next_r.pins.chipSelectBar = 1'b1;
					next_r.pins.outputEnableBar = 1'b1;
					timerLoad = 1'b1;
					timerValue = TIMER_W'(STANDBY_CYCLES);
					next_r.state = ST_RECOVER;
				end
			end

			// Hold the strobe for the long pulse
			ST_WRITE: begin
				if (timerExpired) begin
					// Both rise together, the write ends on this edge
					next_r.pins.chipSelectBar = 1'b1;
					next_r.pins.writeStrobeBar = 1'b1;
					// Lanes released on the same edge, no data hold needed
					next_r.pins.dataOutEnBar = '1;
					timerLoad = 1'b1;
					timerValue = TIMER_W'(STANDBY_CYCLES);
					next_r.state = ST_RECOVER;
				end
			end

			// Quiet gap so no short cycles run together
			ST_RECOVER: begin
				// Standby with lanes released before the next access
				if (timerExpired) begin
					next_r.reqReady = 1'b1;
					next_r.state = ST_IDLE;
				end
			end

			// Suspend interval before calling the memory asleep
			ST_SUSPEND: begin
				// A dropped sleep request waits until asleep
				if (timerExpired) begin
					next_r.sleeping = 1'b1;
					next_r.state = ST_SLEEP;
				end
			end

			// Wait for the wake request
			ST_SLEEP: begin
				// Waking repeats the full power-up wait
				if (!sleepReq) begin
					next_r.sleeping = 1'b0;
					next_r.pins.deepSleepBar = 1'b1;
					next_r.pins.chipSelectBar = 1'b1;
					timerLoad = 1'b1;
					timerValue = TIMER_W'(POWERUP_CYCLES);
					next_r.state = ST_POWERUP;
				end
			end
		endcase
	end

	// State register, all control pins idle high after reset
	always_ff @(posedge clk) begin
		if (reset) begin
			r <= '0;
			r.state <= ST_START;
			r.pins.chipSelectBar <= 1'b1;
			r.pins.deepSleepBar <= 1'b1;
			r.pins.outputEnableBar <= 1'b1;
			r.pins.writeStrobeBar <= 1'b1;
			r.pins.lowLaneEnableBar <= 1'b1;
			r.pins.highLaneEnableBar <= 1'b1;
			r.pins.dataOutEnBar <= '1;
		end else begin
			r <= next_r;
		end
	end

	// Outputs straight from the state register
	assign reqReady = r.reqReady;
	assign rspValid = r.rspValid;
	assign rspData = r.rspData;
	assign sleeping = r.sleeping;
	assign linkReady = r.linkReady;

	// Memory pins, each from its own flip-flop
	assign chipSelectBar = r.pins.chipSelectBar;
	assign deep_sleep_bar = r.pins.deepSleepBar;
	assign outputEnableBar = r.pins.outputEnableBar;
	assign writeStrobeBar = r.pins.writeStrobeBar;
	assign low_lane_enable_bar = r.pins.lowLaneEnableBar;
	assign high_lane_enable_bar = r.pins.highLaneEnableBar;
	assign word_address = r.pins.wordAddress;
	assign dataOut = r.pins.dataOut;
	assign dataOutEnBar = r.pins.dataOutEnBar;

endmodule : apsi_ctrl

// *** design/apsi_pkg.sv ***
package apsi_pkg;

	// Clock rate
	localparam int CLK_MHZ = 50;

	// Memory geometry
	localparam int ADDR_W = 21;
	localparam int DATA_W = 16;
	localparam int LANE_W = 8;
	localparam int LANES = 2;

	// Times in their own units
	localparam int POWERUP_US = 200;
	localparam int SUSPEND_NS = 500;
	localparam int READ_CYCLE_NS = 70;
	localparam int WRITE_PULSE_MIN_NS = 70;
	localparam int TURN_NS = 25;

	// Cycle counts, least times rounded up
	localparam int POWERUP_CYCLES_DEF = POWERUP_US * CLK_MHZ;
	localparam int SUSPEND_CYCLES = (SUSPEND_NS * CLK_MHZ + 999) / 1000;
	localparam int READ_CYCLES = (READ_CYCLE_NS * CLK_MHZ + 999) / 1000;
	localparam int WRITE_PULSE_CYCLES = (WRITE_PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int TURN_CYCLES = (TURN_NS * CLK_MHZ + 999) / 1000;
	localparam int STANDBY_CYCLES = (READ_CYCLES > TURN_CYCLES) ? READ_CYCLES : TURN_CYCLES;

	// Timer width, holds the power-up count
	localparam int TIMER_W = 14;

	// Controller states
	typedef enum logic [2:0] {
		ST_START = 3'h0,
		ST_POWERUP = 3'h1,
		ST_IDLE = 3'h2,
		ST_READ = 3'h3,
		ST_WRITE = 3'h4,
		ST_RECOVER = 3'h5,
		ST_SUSPEND = 3'h6,
		ST_SLEEP = 3'h7
	} apsi_state_e;

	// Pins toward the memory
	typedef struct packed {
		logic chipSelectBar;
		logic deepSleepBar;
		logic outputEnableBar;
		logic writeStrobeBar;
		logic lowLaneEnableBar;
		logic highLaneEnableBar;
		logic [ADDR_W-1:0] wordAddress;
		logic [DATA_W-1:0] dataOut;
		logic [LANES-1:0] dataOutEnBar;
	} apsi_pins_s;

	// Whole controller state
	typedef struct packed {
		apsi_state_e state;
		apsi_pins_s pins;
		logic reqReady;
		logic rspValid;
		logic [DATA_W-1:0] rspData;
		logic sleeping;
		logic linkReady;
	} apsi_ctrl_s;

	// Timer state
	typedef struct packed {
		logic [TIMER_W-1:0] count;
	} apsi_timer_s;

endpackage : apsi_pkg

// *** design/apsi_timer.sv ***
`timescale 1ns/1ps

module apsi_timer
	import apsi_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic load,
	input wire logic [TIMER_W-1:0] loadValue,
	output logic expired
);

	apsi_timer_s r;
	apsi_timer_s next_r;

	// Load wins, otherwise count down to zero and stop
	always_comb begin
		next_r = r;
		if (load) begin
			next_r.count = loadValue;
		end else if (r.count != '0) begin
			next_r.count = r.count - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// Zero means the interval has run out
	assign expired = (r.count == '0);

endmodule : apsi_timer

// *** verification/apsi_chk.sv ***
`timescale 1ns/1ps
module apsi_chk
	import apsi_pkg::*;
#(
	parameter int POWERUP_CYCLES = POWERUP_CYCLES_DEF
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic reqValid,
	input wire logic reqWrite,
	input wire logic reqReady,
	input wire logic rspValid,
	input wire logic sleeping,
	input wire logic linkReady,
	input wire logic chipSelectBar,
	input wire logic deep_sleep_bar,
	input wire logic writeStrobeBar,
	input wire logic low_lane_enable_bar,
	input wire logic high_lane_enable_bar,
	input wire logic [LANES-1:0] dataOutEnBar
);
	logic [15:0] hiCnt;
	logic [15:0] sleepCnt;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	// Saturating counts of quiet select time and of deep sleep time
	always_ff @(posedge clk) begin
		hiCnt <= (reset || !chipSelectBar || !deep_sleep_bar) ? 16'h0 : hiCnt + {15'h0, ~&hiCnt};
		sleepCnt <= (reset || deep_sleep_bar) ? 16'h0 : sleepCnt + {15'h0, ~&sleepCnt};
	end
	AST_POWERUP_WAIT: assert property ($rose(linkReady) |-> hiCnt >= 16'(POWERUP_CYCLES))
		else $error("link ready too early");
	AST_SELECT_LINK: assert property (!chipSelectBar |-> linkReady && deep_sleep_bar)
		else $error("select while not ready");
	AST_WRITE_PULSE: assert property ($fell(writeStrobeBar) |-> (!writeStrobeBar && !chipSelectBar)[*4])
		else $error("write pulse short");
	AST_WRITE_LANES: assert property (!writeStrobeBar |-> dataOutEnBar == {high_lane_enable_bar, low_lane_enable_bar})
		else $error("driven lanes differ");
	AST_NO_DRIVE: assert property (writeStrobeBar |-> dataOutEnBar == 2'h3)
		else $error("lane driven outside write");
	AST_WRITE_END: assert property ($rose(writeStrobeBar) |-> $rose(chipSelectBar))
		else $error("write end apart");
	AST_STANDBY_GAP: assert property ($rose(chipSelectBar) |-> chipSelectBar[*4])
		else $error("standby short");
	AST_SUSPEND: assert property ($rose(sleeping) |-> sleepCnt >= 16'(SUSPEND_CYCLES))
		else $error("suspend short");
	AST_READ_ANSWER: assert property (reqValid && reqReady && !reqWrite |-> ##6 rspValid)
		else $error("read answer late");
endmodule : apsi_chk
bind apsi_ctrl apsi_chk #(.POWERUP_CYCLES(POWERUP_CYCLES)) chk (.clk, .reset, .reqValid, .reqWrite,
	.reqReady, .rspValid, .sleeping, .linkReady, .chipSelectBar, .deep_sleep_bar, .writeStrobeBar,
	.low_lane_enable_bar, .high_lane_enable_bar, .dataOutEnBar);

// *** verification/apsi_mem.sv ***
`timescale 1ns/1ps
module apsi_mem
	import apsi_pkg::*;
(
	input wire logic clk,
	input wire apsi_pins_s p,
	output logic [DATA_W-1:0] q
);
	logic [DATA_W-1:0] mem [int];
	logic [DATA_W-1:0] w;
	logic [1:0] en;
	assign en = ~{p.highLaneEnableBar, p.lowLaneEnableBar};
	initial q = '0;
	// Word store on the 21-bit address, wiped by deep sleep
	always @(posedge clk) begin
		w = mem.exists(p.wordAddress) ? mem[p.wordAddress] : '0;
		if (!p.deepSleepBar)
			mem.delete();
		else if (!p.chipSelectBar && !p.writeStrobeBar) begin
			for (int i = 0; i < 2; i++)
				if (en[i])
					w[i*8 +: 8] = p.dataOutEnBar[i] ? ~w[i*8 +: 8] : p.dataOut[i*8 +: 8];
			mem[p.wordAddress] = w;
		end
		// Enabled read lanes driven, the rest toggle as undriven
		for (int i = 0; i < 2; i++)
			q[i*8 +: 8] <= (!p.chipSelectBar && p.deepSleepBar && !p.outputEnableBar && p.writeStrobeBar && en[i])
				? w[i*8 +: 8] : ~q[i*8 +: 8];
	end
endmodule : apsi_mem

// *** verification/testbench.sv ***
`timescale 1ns/1ps
module testbench;
	import apsi_pkg::*;
	localparam int PUC = 20;
	logic clk, reset, reqValid, reqWrite, sleepReq, reqReady, rspValid, sleeping, linkReady;
	logic [ADDR_W-1:0] reqAddr;
	logic [DATA_W-1:0] reqData, rspData, q;
	logic [1:0] reqLaneEn;
	wire apsi_pins_s p;
	int err_count = 0;
	int total_checks = 0;
	apsi_ctrl #(.POWERUP_CYCLES(PUC)) uut (.clk, .reset, .reqValid, .reqWrite, .reqAddr, .reqData,
		.reqLaneEn, .reqReady, .rspValid, .rspData, .sleepReq, .sleeping, .linkReady,
		.chipSelectBar(p.chipSelectBar), .deep_sleep_bar(p.deepSleepBar), .outputEnableBar(p.outputEnableBar),
		.writeStrobeBar(p.writeStrobeBar), .low_lane_enable_bar(p.lowLaneEnableBar),
		.high_lane_enable_bar(p.highLaneEnableBar), .word_address(p.wordAddress), .dataOut(p.dataOut),
		.dataOutEnBar(p.dataOutEnBar), .dataIn(q));
	apsi_mem mem (.clk, .p, .q);
	// Clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wait_ready(output int n);
		n = 0;
		while (reqReady !== 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		chk("ready wait", 16'h1, {15'h0, reqReady});
	endtask : wait_ready
	task automatic acc(input logic wr, input logic [ADDR_W-1:0] a, input logic [15:0] d,
		input logic [1:0] en, output logic [15:0] v);
		int n;
		wait_ready(n);
		reqValid = 1'b1;
		reqWrite = wr;
		reqAddr = a;
		reqData = d;
		reqLaneEn = en;
		@(negedge clk);
		reqValid = 1'b0;
		n = 0;
		while (!wr && rspValid !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		if (!wr)
			chk("read answer", 16'h1, {15'h0, rspValid});
		v = rspData;
	endtask : acc
	task automatic t_lanes();
		logic [15:0] v;
		logic [15:0] ex;
		logic [15:0] mk;
		logic [15:0] wm;
		ex = 16'ha55a;
		acc(1'b1, 21'h1fffff, ex, 2'h3, v);
		acc(1'b1, 21'h0, 16'h0f0f, 2'h3, v);
		for (int e = 0; e < 4; e++) begin
			wm = {{8{e[1]}}, {8{e[0]}}};
			acc(1'b1, 21'h1fffff, 16'hc3c3 + 16'(e), 2'(e), v);
			ex = (ex & ~wm) | ((16'hc3c3 + 16'(e)) & wm);
			// No lane written: read the whole word back instead
			mk = (e == 0) ? 16'hffff : wm;
			acc(1'b0, 21'h1fffff, 16'h0, (e == 0) ? 2'h3 : 2'(e), v);
			chk("lane read", ex & mk, v & mk);
		end
		acc(1'b0, 21'h1fffff, 16'h0, 2'h3, v);
		chk("word read", ex, v);
		acc(1'b0, 21'h0, 16'h0, 2'h3, v);
		chk("low word", 16'h0f0f, v);
		$display("test lanes done");
	endtask : t_lanes
	task automatic t_sleep();
		int n;
		logic [15:0] v;
		sleepReq = 1'b1;
		n = 0;
		while (p.deepSleepBar !== 1'b0 && n < 100) begin
			@(negedge clk);
			n++;
		end
		n = 0;
		while (sleeping !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		chk("sleep reached", 16'h1, {15'h0, sleeping});
		chk("suspend wait", 16'h1, 16'(n >= SUSPEND_CYCLES));
		chk("sleep pins", 16'h0, {15'h0, p.deepSleepBar | linkReady});
		sleepReq = 1'b0;
		wait_ready(n);
		chk("wake wait", 16'h1, 16'(n >= PUC));
		chk("link again", 16'h1, {15'h0, linkReady});
		acc(1'b0, 21'h1fffff, 16'h0, 2'h3, v);
		chk("contents lost", 16'h0, v);
		$display("test sleep done");
	endtask : t_sleep
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test
	// Main sequence
	initial begin
		int n;
		reset = 1'b1;
		reqValid = 1'b0;
		reqWrite = 1'b0;
		reqAddr = '0;
		reqData = '0;
		reqLaneEn = '0;
		sleepReq = 1'b0;
		repeat (20) @(negedge clk);
		reset = 1'b0;
		wait_ready(n);
		chk("powerup wait", 16'h1, 16'(n >= PUC));
		chk("link up", 16'h1, {15'h0, linkReady});
		$display("test powerup done");
		t_lanes();
		t_sleep();
		finish_test();
	end
	// Watchdog
	initial begin
		#200us;
		err_count++;
		finish_test();
	end
endmodule : testbench
